// file: qie_defines.svh
// constants of the invalidation engine
`ifndef QIE_DEFINES_SVH
`define QIE_DEFINES_SVH

`define QIE_ADDR_W        8
`define QIE_A_CTRL        8'h00
`define QIE_A_STAT        8'h04
`define QIE_A_BASE_LO     8'h08
`define QIE_A_BASE_HI     8'h0c
`define QIE_A_QSIZE       8'h10
`define QIE_A_HEAD        8'h14
`define QIE_A_TAIL        8'h18

`define QIE_CTRL_EN       0
`define QIE_STAT_QMES     0
`define QIE_STAT_QEF      1
`define QIE_STAT_ITF      2

`define QIE_PTR_W         15
`define QIE_QSIZE_W       3
`define QIE_BASE_W        52
`define QIE_BASE_LSB      12
`define QIE_QMIN          16'h0100

`define QIE_T_NONE        4'h0
`define QIE_T_CC          4'h1
`define QIE_T_PC          4'h7
`define QIE_F_TYPE        3:0
`define QIE_F_GRAN        5:4
`define QIE_F_DID         31:16
`define QIE_F_SID         47:32
`define QIE_F_FM          49:48
`define QIE_F_PASID       51:32

`define QIE_CC_RSVD       2'b00
`define QIE_CC_GLOBAL     2'b01
`define QIE_CC_DOMAIN     2'b10
`define QIE_CC_DEVICE     2'b11
`define QIE_PC_ALL        2'b00
`define QIE_PC_SEL        2'b01

`define QIE_RESP_OKAY     2'b00
`define QIE_RESP_SLVERR   2'b10

`endif

// file: qie_pkg.sv
// types shared by the invalidation engine modules
`include "qie_defines.svh"
package qie_pkg;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_REQ   = 5'h02,
      ST_WAIT  = 5'h04,
      ST_FLUSH = 5'h08,
      ST_ISSUE = 5'h10
   } qie_state_t;

   typedef struct packed {
      qie_state_t                st;
      logic                      ctrl_en;
      logic                      qmes;
      logic                      qef;
      logic                      itf;
      logic [`QIE_BASE_W-1:0]    base;
      logic [`QIE_QSIZE_W-1:0]   qsize;
      logic [`QIE_PTR_W-1:0]     head;
      logic [`QIE_PTR_W-1:0]     tail;
      logic [63:0]               mem_addr;
      logic [127:0]              desc;
      logic [3:0]                o_type;
      logic [1:0]                o_gran;
      logic [15:0]               o_did;
      logic [15:0]               o_sid;
      logic [1:0]                o_fm;
      logic [19:0]               o_pasid;
   } qie_core_t;

   typedef struct packed {
      logic                      aw_held;
      logic [`QIE_ADDR_W-1:0]    awaddr;
      logic                      w_held;
      logic [31:0]               wdata;
      logic [3:0]                wstrb;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
   } qie_port_t;

endpackage : qie_pkg

// file: qie_axil_port.sv
// axi4-lite slave front end producing register strobes
`timescale 1ns/1ps
`include "qie_defines.svh"
module qie_axil_port (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   s_axil_awvalid,
   output logic                        s_axil_awready,
   input  wire logic [`QIE_ADDR_W-1:0] s_axil_awaddr,
   input  wire logic                   s_axil_wvalid,
   output logic                        s_axil_wready,
   input  wire logic [31:0]            s_axil_wdata,
   input  wire logic [3:0]             s_axil_wstrb,
   output logic                        s_axil_bvalid,
   input  wire logic                   s_axil_bready,
   output logic [1:0]                  s_axil_bresp,
   input  wire logic                   s_axil_arvalid,
   output logic                        s_axil_arready,
   input  wire logic [`QIE_ADDR_W-1:0] s_axil_araddr,
   output logic                        s_axil_rvalid,
   input  wire logic                   s_axil_rready,
   output logic [31:0]                 s_axil_rdata,
   output logic [1:0]                  s_axil_rresp,
   output logic                        wr_en,
   output logic [`QIE_ADDR_W-1:0]      wr_addr,
   output logic [31:0]                 wr_data,
   output logic [3:0]                  wr_strb,
   input  wire logic                   wr_ok,
   output logic [`QIE_ADDR_W-1:0]      rd_addr,
   input  wire logic [31:0]            rd_data,
   input  wire logic                   rd_ok
);

   qie_pkg::qie_port_t r;
   qie_pkg::qie_port_t next_r;

   // address and data are held apart so either may arrive first
   assign s_axil_awready = !r.aw_held && !r.bvalid;
   assign s_axil_wready  = !r.w_held && !r.bvalid;
   assign s_axil_arready = !r.rvalid;
   assign s_axil_bvalid  = r.bvalid;
   assign s_axil_bresp   = r.bresp;
   assign s_axil_rvalid  = r.rvalid;
   assign s_axil_rdata   = r.rdata;
   assign s_axil_rresp   = r.rresp;
   assign wr_en          = r.aw_held && r.w_held;
   assign wr_addr        = r.awaddr;
   assign wr_data        = r.wdata;
   assign wr_strb        = r.wstrb;
   assign rd_addr        = s_axil_araddr;

   // one write and one read in flight
   always_comb begin
      next_r = r;
      if (s_axil_awvalid && s_axil_awready) begin
         next_r.aw_held = 1'b1;
         next_r.awaddr  = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
         next_r.w_held = 1'b1;
         next_r.wdata  = s_axil_wdata;
         next_r.wstrb  = s_axil_wstrb;
      end
      if (wr_en) begin
         next_r.aw_held = 1'b0;
         next_r.w_held  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = wr_ok ? `QIE_RESP_OKAY : `QIE_RESP_SLVERR;
      end else if (r.bvalid && s_axil_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (s_axil_arvalid && s_axil_arready) begin
         next_r.rvalid = 1'b1;
         next_r.rdata  = rd_ok ? rd_data : 32'h0000_0000; // unmapped reads as zero
         next_r.rresp  = rd_ok ? `QIE_RESP_OKAY : `QIE_RESP_SLVERR;
      end else if (r.rvalid && s_axil_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule : qie_axil_port

// file: qie_desc_decode.sv
// combinational decode of one 128-bit invalidation descriptor
`timescale 1ns/1ps
`include "qie_defines.svh"
module qie_desc_decode #(
   parameter int DID_W      = 16,
   parameter bit WRITE_BUFFER_FLUSH_REQUIRED       = 1'b1,
   parameter bit CC_DEV_SEL = 1'b1,
   parameter bit PC_SEL     = 1'b1
) (
   input  wire logic [127:0] desc,
   output logic [3:0]        dtype,
   output logic              dvalid,
   output logic [1:0]        gran,
   output logic [15:0]       domain_identifier,
   output logic [15:0]       source_identifier,
   output logic [1:0]        fm,
   output logic [19:0]       pasid,
   output logic              flush
);

   localparam logic [15:0] DID_MASK = 16'((32'h1 << DID_W) - 32'h1);

   generate
      if (DID_W < 1 || DID_W > 16) begin : g_bad_did
         $error("domain identifier width must be 1 to 16");
      end
   endgenerate

   // unused fields forced to zero
   always_comb begin
      dtype  = desc[`QIE_F_TYPE];
      gran   = desc[`QIE_F_GRAN];
      dvalid = dtype != `QIE_T_NONE;
      domain_identifier    = 16'h0000;
      source_identifier    = 16'h0000;
      fm     = 2'b00;
      pasid  = 20'h00000;
      flush  = 1'b0;
      if (dtype == `QIE_T_CC) begin
         dvalid = gran != `QIE_CC_RSVD;
         if (gran == `QIE_CC_DEVICE && !CC_DEV_SEL) begin
            gran = `QIE_CC_DOMAIN;
         end
         if (gran != `QIE_CC_GLOBAL) begin
            domain_identifier = desc[`QIE_F_DID] & DID_MASK;
         end
         if (gran == `QIE_CC_DEVICE) begin
            source_identifier = desc[`QIE_F_SID];
            fm  = desc[`QIE_F_FM];
         end
         flush = WRITE_BUFFER_FLUSH_REQUIRED;
      end else if (dtype == `QIE_T_PC) begin
         dvalid = gran == `QIE_PC_ALL || gran == `QIE_PC_SEL;
         if (gran == `QIE_PC_SEL && !PC_SEL) begin
            gran = `QIE_PC_ALL;
         end
         domain_identifier = desc[`QIE_F_DID] & DID_MASK;
         if (gran == `QIE_PC_SEL) begin
            pasid = desc[`QIE_F_PASID];
         end
         flush = WRITE_BUFFER_FLUSH_REQUIRED;
      end
   end

endmodule : qie_desc_decode

// file: qie_engine.sv
// queued invalidation engine: register file, queue fetch sequencer and command issue
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "qie_defines.svh"
module qie_engine #(
   parameter int DID_W      = 16,
   parameter bit WRITE_BUFFER_FLUSH_REQUIRED       = 1'b1,
   parameter bit CC_DEV_SEL = 1'b1,
   parameter bit PC_SEL     = 1'b1
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   s_axil_awvalid,
   output logic                        s_axil_awready,
   input  wire logic [`QIE_ADDR_W-1:0] s_axil_awaddr,
   input  wire logic                   s_axil_wvalid,
   output logic                        s_axil_wready,
   input  wire logic [31:0]            s_axil_wdata,
   input  wire logic [3:0]             s_axil_wstrb,
   output logic                        s_axil_bvalid,
   input  wire logic                   s_axil_bready,
   output logic [1:0]                  s_axil_bresp,
   input  wire logic                   s_axil_arvalid,
   output logic                        s_axil_arready,
   input  wire logic [`QIE_ADDR_W-1:0] s_axil_araddr,
   output logic                        s_axil_rvalid,
   input  wire logic                   s_axil_rready,
   output logic [31:0]                 s_axil_rdata,
   output logic [1:0]                  s_axil_rresp,
   output logic                        mem_req_valid,
   input  wire logic                   mem_req_ready,
   output logic [63:0]                 mem_req_addr,
   input  wire logic                   mem_rsp_valid,
   output logic                        mem_rsp_ready,
   input  wire logic [127:0]           mem_rsp_data,
   input  wire logic                   mem_rsp_err,
   output logic                        wbf_req,
   input  wire logic                   wbf_done,
   input  wire logic                   timeout_event,
   output logic                        inv_valid,
   input  wire logic                   inv_ready,
   output logic [3:0]                  inv_type,
   output logic [1:0]                  inv_gran,
   output logic [15:0]                 inv_did,
   output logic [15:0]                 inv_sid,
   output logic [1:0]                  inv_fm,
   output logic [19:0]                 inv_pasid,
   output logic [127:0]                inv_desc,
   output logic                        queued_mode_enabled_status
);

   localparam qie_pkg::qie_core_t CORE_RST = '{st: qie_pkg::ST_IDLE, default: '0};

   qie_pkg::qie_core_t r;
   qie_pkg::qie_core_t next_r;

   logic                   wr_en;
   logic [`QIE_ADDR_W-1:0] wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   wr_ok;
   logic [`QIE_ADDR_W-1:0] rd_addr;
   logic [31:0]            rd_data;
   logic                   rd_ok;
   logic [3:0]             d_type;
   logic                   d_valid;
   logic [1:0]             d_gran;
   logic [15:0]            d_did;
   logic [15:0]            d_sid;
   logic [1:0]             d_fm;
   logic [19:0]            d_pasid;
   logic                   d_flush;
   logic                   fetch_ok;

   // byte-lane merge of a bus write into a stored word
   function automatic logic [31:0] qie_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : qie_merge

   // slot count is 256 << qsize; the last slot rolls over to zero
   function automatic logic [`QIE_PTR_W-1:0] qie_wrap_inc(input logic [`QIE_PTR_W-1:0] p,
                                                          input logic [`QIE_QSIZE_W-1:0] qs);
      logic [15:0] lim;
      logic [15:0] nxt;
      lim = `QIE_QMIN << qs;
      nxt = {1'b0, p} + 16'h0001;
      return (nxt >= lim) ? '0 : nxt[`QIE_PTR_W-1:0];
   endfunction : qie_wrap_inc

   // word-aligned address compare
   function automatic logic qie_hit(input logic [`QIE_ADDR_W-1:0] a,
                                    input logic [`QIE_ADDR_W-1:0] off);
      return {a[`QIE_ADDR_W-1:2], 2'b00} == off;
   endfunction : qie_hit

   qie_axil_port u_port (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .s_axil_awvalid (s_axil_awvalid),
      .s_axil_awready (s_axil_awready),
      .s_axil_awaddr  (s_axil_awaddr),
      .s_axil_wvalid  (s_axil_wvalid),
      .s_axil_wready  (s_axil_wready),
      .s_axil_wdata   (s_axil_wdata),
      .s_axil_wstrb   (s_axil_wstrb),
      .s_axil_bvalid  (s_axil_bvalid),
      .s_axil_bready  (s_axil_bready),
      .s_axil_bresp   (s_axil_bresp),
      .s_axil_arvalid (s_axil_arvalid),
      .s_axil_arready (s_axil_arready),
      .s_axil_araddr  (s_axil_araddr),
      .s_axil_rvalid  (s_axil_rvalid),
      .s_axil_rready  (s_axil_rready),
      .s_axil_rdata   (s_axil_rdata),
      .s_axil_rresp   (s_axil_rresp),
      .wr_en          (wr_en),
      .wr_addr        (wr_addr),
      .wr_data        (wr_data),
      .wr_strb        (wr_strb),
      .wr_ok          (wr_ok),
      .rd_addr        (rd_addr),
      .rd_data        (rd_data),
      .rd_ok          (rd_ok)
   );

   // decode straight off the response so the check precedes any head move
   qie_desc_decode #(
      .DID_W      (DID_W),
      .WRITE_BUFFER_FLUSH_REQUIRED       (WRITE_BUFFER_FLUSH_REQUIRED),
      .CC_DEV_SEL (CC_DEV_SEL),
      .PC_SEL     (PC_SEL)
   ) u_dec (
      .desc   (mem_rsp_data),
      .dtype  (d_type),
      .dvalid (d_valid),
      .gran   (d_gran),
      .domain_identifier    (d_did),
      .source_identifier    (d_sid),
      .fm     (d_fm),
      .pasid  (d_pasid),
      .flush  (d_flush)
   );

   // read mux; head and tail read as slot indices
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      if (qie_hit(rd_addr, `QIE_A_CTRL)) begin
         rd_data[`QIE_CTRL_EN] = r.ctrl_en;
      end else if (qie_hit(rd_addr, `QIE_A_STAT)) begin
         rd_data[`QIE_STAT_QMES] = r.qmes;
         rd_data[`QIE_STAT_QEF]  = r.qef;
         rd_data[`QIE_STAT_ITF]  = r.itf;
      end else if (qie_hit(rd_addr, `QIE_A_BASE_LO)) begin
         rd_data[31:`QIE_BASE_LSB] = r.base[31-`QIE_BASE_LSB:0];
      end else if (qie_hit(rd_addr, `QIE_A_BASE_HI)) begin
         rd_data = r.base[`QIE_BASE_W-1:32-`QIE_BASE_LSB];
      end else if (qie_hit(rd_addr, `QIE_A_QSIZE)) begin
         rd_data[`QIE_QSIZE_W-1:0] = r.qsize;
      end else if (qie_hit(rd_addr, `QIE_A_HEAD)) begin
         rd_data[`QIE_PTR_W-1:0] = r.head;
      end else if (qie_hit(rd_addr, `QIE_A_TAIL)) begin
         rd_data[`QIE_PTR_W-1:0] = r.tail;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // remap enables deliberately left out
   assign fetch_ok = r.qmes && (r.head != r.tail) && !r.qef && !r.itf;

   // register writes first, then hardware updates, so a set beats a clear
   always_comb begin
      logic [31:0] m;
      next_r = r;
      wr_ok  = 1'b1;
      m      = qie_merge(32'h0000_0000, wr_data, wr_strb);
      if (wr_en) begin
         if (qie_hit(wr_addr, `QIE_A_CTRL)) begin
            if (wr_strb[0]) begin
               next_r.ctrl_en = wr_data[`QIE_CTRL_EN];
            end
         end else if (qie_hit(wr_addr, `QIE_A_STAT)) begin
            // error flags are write-one-to-clear
            if (m[`QIE_STAT_QEF]) begin
               next_r.qef = 1'b0;
            end
            if (m[`QIE_STAT_ITF]) begin
               next_r.itf = 1'b0;
            end
         end else if (qie_hit(wr_addr, `QIE_A_BASE_LO)) begin
            // queue geometry is frozen while enabled so fetch addresses stay coherent
            if (!r.qmes) begin
               m = qie_merge({r.base[31-`QIE_BASE_LSB:0], 12'h000}, wr_data, wr_strb);
               next_r.base[31-`QIE_BASE_LSB:0] = m[31:`QIE_BASE_LSB];
            end
         end else if (qie_hit(wr_addr, `QIE_A_BASE_HI)) begin
            if (!r.qmes) begin
               next_r.base[`QIE_BASE_W-1:32-`QIE_BASE_LSB] =
                  qie_merge(r.base[`QIE_BASE_W-1:32-`QIE_BASE_LSB], wr_data, wr_strb);
            end
         end else if (qie_hit(wr_addr, `QIE_A_QSIZE)) begin
            if (!r.qmes && wr_strb[0]) begin
               next_r.qsize = wr_data[`QIE_QSIZE_W-1:0];
            end
         end else if (qie_hit(wr_addr, `QIE_A_TAIL)) begin
            m = qie_merge({17'h00000, r.tail}, wr_data, wr_strb);
            next_r.tail = m[`QIE_PTR_W-1:0];
         end else if (!qie_hit(wr_addr, `QIE_A_HEAD)) begin
            wr_ok = 1'b0; // unmapped address
         end
      end
      if (timeout_event) begin
         next_r.itf = 1'b1;
      end
      case (r.st)
         qie_pkg::ST_IDLE: begin
            // enable and disable act only between descriptors
            if (r.qmes && !r.ctrl_en) begin
               next_r.qmes = 1'b0;
               next_r.head = '0;
            end else if (!r.qmes && r.ctrl_en) begin
               next_r.qmes = 1'b1;
            end else if (fetch_ok) begin
               next_r.mem_addr = {r.base, 12'h000}
                               + {45'h0, r.head, 4'h0};
               next_r.st = qie_pkg::ST_REQ;
            end
         end
         qie_pkg::ST_REQ: begin
            if (mem_req_ready) begin
               next_r.st = qie_pkg::ST_WAIT;
            end
         end
         qie_pkg::ST_WAIT: begin
            if (mem_rsp_valid) begin
               if (mem_rsp_err || !d_valid) begin
                  next_r.qef = 1'b1; // head stays on the bad slot
                  next_r.st  = qie_pkg::ST_IDLE;
               end else begin
                  next_r.desc    = mem_rsp_data;
                  next_r.o_type  = d_type;
                  next_r.o_gran  = d_gran;
                  next_r.o_did   = d_did;
                  next_r.o_sid   = d_sid;
                  next_r.o_fm    = d_fm;
                  next_r.o_pasid = d_pasid;
                  next_r.st = d_flush ? qie_pkg::ST_FLUSH : qie_pkg::ST_ISSUE;
               end
            end
         end
         qie_pkg::ST_FLUSH: begin
            if (wbf_done) begin
               next_r.st = qie_pkg::ST_ISSUE;
            end
         end
         qie_pkg::ST_ISSUE: begin
            if (inv_ready) begin
               next_r.head = qie_wrap_inc(r.head, r.qsize);
               next_r.st   = qie_pkg::ST_IDLE;
            end
         end
         default: begin
            next_r.st = qie_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= CORE_RST;
      end else begin
         r <= next_r;
      end
   end

   // handshakes from state, payloads from flops
   assign mem_req_valid = r.st == qie_pkg::ST_REQ;
   assign mem_req_addr  = r.mem_addr;
   assign mem_rsp_ready = r.st == qie_pkg::ST_WAIT;
   assign wbf_req       = r.st == qie_pkg::ST_FLUSH;
   assign inv_valid     = r.st == qie_pkg::ST_ISSUE;
   assign inv_type      = r.o_type;
   assign inv_gran      = r.o_gran;
   assign inv_did       = r.o_did;
   assign inv_sid       = r.o_sid;
   assign inv_fm        = r.o_fm;
   assign inv_pasid     = r.o_pasid;
   assign inv_desc      = r.desc;
   assign queued_mode_enabled_status = r.qmes;

endmodule : qie_engine

// file: qie_sva.sv
// port assertions of the queued invalidation engine
`timescale 1ns/1ps
`include "qie_defines.svh"
module qie_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        mem_req_valid,
   input wire logic        mem_req_ready,
   input wire logic        wbf_req,
   input wire logic        inv_valid,
   input wire logic        inv_ready,
   input wire logic [3:0]  inv_type,
   input wire logic [1:0]  inv_gran,
   input wire logic [15:0] inv_sid,
   input wire logic [19:0] inv_pasid,
   input wire logic        queued_mode_enabled_status
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire qm = queued_mode_enabled_status;
   wire rq = mem_req_valid && !mem_req_ready;
   wire iw = inv_valid && !inv_ready;
   wire cc = inv_valid && inv_type == `QIE_T_CC;
   wire pc = inv_valid && inv_type == `QIE_T_PC;
   // handshake holding, fetch gating, flush order and field decode
   a_req_hold: assert property (rq |=> mem_req_valid) else $error("fetch dropped");
   a_fetch_gate: assert property ($rose(mem_req_valid) |-> $past(qm)) else $error("fetch off");
   a_inv_hold: assert property (iw |=> inv_valid && $stable(inv_pasid)) else $error("cmd");
   a_flush_first: assert property ($rose(cc || pc) |-> $past(wbf_req) || $past(wbf_req, 2))
      else $error("no flush");
   a_cc_gran: assert property (cc |-> inv_gran != 2'h0) else $error("cc gran");
   a_pc_gran: assert property (pc |-> !inv_gran[1]) else $error("pc gran");
   a_pasid_ign: assert property (pc && inv_gran == 2'h0 |-> inv_pasid == 20'h0) else $error("pasid");
   a_cc_sid: assert property (cc && inv_gran != 2'h3 |-> inv_sid == 16'h0) else $error("sid");
endmodule : qie_sva
bind qie_engine qie_sva sva_u (.aclk, .aresetn, .mem_req_valid, .mem_req_ready, .wbf_req,
   .inv_valid, .inv_ready, .inv_type, .inv_gran, .inv_sid, .inv_pasid, .queued_mode_enabled_status);

// file: qie_mem_model.sv
// memory, flush and command partner of the invalidation engine
`timescale 1ns/1ps
module qie_mem_model (
   input  wire logic        aclk,
   input  wire logic [3:0]  slow,
   input  wire logic        mem_req_valid,
   output logic             mem_req_ready,
   input  wire logic [63:0] mem_req_addr,
   input  wire logic        mem_rsp_ready,
   output logic             mem_rsp_valid,
   output logic [127:0]     mem_rsp_data,
   input  wire logic        wbf_req,
   output logic             wbf_done,
   input  wire logic        inv_valid,
   output logic             inv_ready
);
   logic [127:0] q [256]; // descriptor ring
   logic [7:0]   slot = 8'h0;
   logic [3:0]   cnt = 4'h0;
   wire rq_w = mem_req_valid && !mem_req_ready;
   wire want = rq_w || mem_rsp_ready && !mem_rsp_valid || wbf_req && !wbf_done
               || inv_valid && !inv_ready;
   initial {mem_req_ready, mem_rsp_valid, wbf_done, inv_ready, mem_rsp_data} = '0;
   // answers after slow cycles; idle data toggles
   always @(posedge aclk) begin
      {mem_req_ready, mem_rsp_valid, wbf_done, inv_ready} <= 4'h0;
      mem_rsp_data <= ~mem_rsp_data;
      cnt <= want ? cnt + 4'h1 : 4'h0;
      if (mem_req_valid && mem_req_ready) slot <= mem_req_addr[11:4];
      if (want && cnt >= slow) begin
         cnt <= 4'h0;
         mem_req_ready <= rq_w;
         mem_rsp_valid <= mem_rsp_ready && !mem_rsp_valid;
         mem_rsp_data <= q[slot];
         wbf_done <= wbf_req && !wbf_done;
         inv_ready <= inv_valid && !inv_ready;
      end
   end
endmodule : qie_mem_model

// file: qie_tb.sv
// self-checking bench of the queued invalidation engine
`timescale 1ns/1ps
`include "qie_defines.svh"
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, timeout_event = 1'b0, mem_rsp_err = 1'b0;
   logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
   logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, queued_mode_enabled_status;
   logic [7:0] s_axil_awaddr = 8'h0, s_axil_araddr = 8'h0;
   logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
   logic [3:0] s_axil_wstrb = 4'hf, slow = 4'h2, inv_type;
   logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, inv_ready;
   logic mem_req_valid, mem_req_ready, mem_rsp_valid, mem_rsp_ready, wbf_req, wbf_done, inv_valid;
   logic [1:0] s_axil_bresp, s_axil_rresp, inv_gran, inv_fm;
   logic [15:0] inv_did, inv_sid;
   logic [19:0] inv_pasid;
   logic [63:0] mem_req_addr;
   logic [127:0] mem_rsp_data, inv_desc;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   qie_engine dut_u (.*);
   qie_mem_model mem_u (.*);
   always #5 aclk = ~aclk;
   task chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task summarize;
      if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // one axi4-lite transfer; ready sampled at the falling edge
   task bus(input logic w, input logic [7:0] a, inout logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      if (w) {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_awaddr, s_axil_wdata} <= {3'h7, a, d};
      else {s_axil_arvalid, s_axil_rready, s_axil_araddr} <= {2'h3, a};
      forever begin
         @(negedge aclk);
         ta = s_axil_awvalid && s_axil_awready || s_axil_arvalid && s_axil_arready;
         tw = s_axil_wvalid && s_axil_wready;
         tb = s_axil_bvalid || s_axil_rvalid;
         r = w ? s_axil_bresp : s_axil_rresp;
         if (!w) d = s_axil_rdata;
         @(posedge aclk);
         if (ta) {s_axil_awvalid, s_axil_arvalid} <= 2'h0;
         if (tw) s_axil_wvalid <= 1'b0;
         if (tb) begin
            {s_axil_bready, s_axil_rready} <= 2'h0;
            break;
         end
      end
      @(posedge aclk);
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      bus(1'b1, a, d, r);
      chk({30'h0, r}, {30'h0, `QIE_RESP_OKAY});
   endtask : wr
   // polls a register
   task poll(input logic [7:0] a, input logic [31:0] m, e);
      logic [31:0] d;
      logic [1:0] r;
      repeat (1000) begin
         bus(1'b0, a, d, r);
         if ((d & m) === e) break;
      end
      chk(d & m, e);
   endtask : poll
   task inv(input logic [3:0] t, input logic [1:0] g, input logic [15:0] domain_identifier, source_identifier, input logic [19:0] p);
      forever begin
         @(negedge aclk);
         if (inv_valid && inv_ready) break;
      end
      chk({4'h0, inv_desc[5:0], inv_type, inv_gran, inv_did}, {4'h0, g, t, t, g, domain_identifier});
      if (t == `QIE_T_CC) chk({14'h0, inv_fm, inv_sid}, {14'h0, g == `QIE_CC_DEVICE, 1'b0, source_identifier});
      else chk({12'h0, inv_pasid}, {12'h0, p});
   endtask : inv
   function logic [127:0] dsc(input logic [3:0] t, input logic [1:0] g, input logic [15:0] i);
      return {76'h0, 20'h2abcd, i, 10'h0, g, t}; // reserved fields left zero
   endfunction : dsc
   task t_enable;
      wr(`QIE_A_TAIL, 32'h0);
      wr(`QIE_A_BASE_LO, 32'h0000_3000);
      wr(`QIE_A_CTRL, 32'h1);
      poll(`QIE_A_STAT, 32'h1, 32'h1);
   endtask : t_enable
   task t_decode;
      logic [31:0] d;
      logic [1:0] r;
      bus(1'b0, 8'h40, d, r);
      chk({30'h0, r}, {30'h0, `QIE_RESP_SLVERR});
      wr(`QIE_A_TAIL, 32'h5);
      inv(`QIE_T_CC, `QIE_CC_GLOBAL, 16'h0, 16'h0, 20'h0);
      inv(`QIE_T_CC, `QIE_CC_DOMAIN, 16'h0042, 16'h0, 20'h0);
      inv(`QIE_T_CC, `QIE_CC_DEVICE, 16'h0042, 16'habcd, 20'h0);
      inv(`QIE_T_PC, `QIE_PC_ALL, 16'h0007, 16'h0, 20'h0);
      inv(`QIE_T_PC, `QIE_PC_SEL, 16'h0007, 16'h0, 20'h2abcd);
      @(posedge aclk);
      poll(`QIE_A_HEAD, 32'h7fff, 32'h5);
   endtask : t_decode
   task t_error;
      wr(`QIE_A_TAIL, 32'h6);
      poll(`QIE_A_STAT, 32'h2, 32'h2);
      timeout_event <= 1'b1;
      @(posedge aclk);
      timeout_event <= 1'b0;
      mem_u.q[5] = dsc(4'h2, 2'h0, 16'h0); // iotlb stand
      wr(`QIE_A_STAT, 32'h2);
      poll(`QIE_A_STAT, 32'h6, 32'h4);
      poll(`QIE_A_HEAD, 32'h7fff, 32'h5);
      wr(`QIE_A_STAT, 32'h4);
      poll(`QIE_A_HEAD, 32'h7fff, 32'h6);
   endtask : t_error
   task t_wrap;
      wr(`QIE_A_CTRL, 32'h0);
      poll(`QIE_A_STAT, 32'h1, 32'h0);
      poll(`QIE_A_HEAD, 32'h7fff, 32'h0);
      slow <= 4'h0;
      t_enable;
      wr(`QIE_A_TAIL, 32'hff);
      poll(`QIE_A_HEAD, 32'h7fff, 32'hff);
      wr(`QIE_A_TAIL, 32'h0);
      poll(`QIE_A_HEAD, 32'h7fff, 32'h0);
   endtask : t_wrap
   initial begin
      foreach (mem_u.q[i]) mem_u.q[i] = dsc(4'h2, 2'h0, 16'h0);
      mem_u.q[0] = dsc(`QIE_T_CC, `QIE_CC_GLOBAL, 16'h1234);
      mem_u.q[1] = dsc(`QIE_T_CC, `QIE_CC_DOMAIN, 16'h0042);
      mem_u.q[2] = dsc(`QIE_T_CC, `QIE_CC_DEVICE, 16'h0042);
      mem_u.q[3] = dsc(`QIE_T_PC, `QIE_PC_ALL, 16'h0007);
      mem_u.q[4] = dsc(`QIE_T_PC, `QIE_PC_SEL, 16'h0007);
      mem_u.q[5] = 128'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_enable;
      t_decode;
      t_error;
      t_wrap;
      summarize;
   end
   // hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         summarize;
      end
   end
endmodule : testbench
